//--- rtl/stb_unit.sv
`timescale 1ns/1ps

// Summary of operation
// - left shift: bits move up, zero enters bit 0, old bit 7 to carry
// - left shift flags: V = b7 xor b6, N from b6 (result bit 7), Z on zero
// - right shift: bits move down, bit 7 held so sign replicates
// - right shift flags: C = old bit 0, N, Z; V kept, H undefined
// - every jump has short and long form; taken loads pc plus offset
// - short form offset is one signed byte added to pc
// - long form offset is a signed 16-bit word added to pc
// - carry-clear jump taken only when C is 0
// - carry-set jump taken only when C is 1
// - higher-same and lower are aliases of carry-clear and carry-set codes
// - equal jump taken only when Z is 1
// - not-equal jump taken only when Z is 0
// - greater-equal jump taken only when N xor V is 0
// - greater jump taken only when Z or (N xor V) is 0
// - higher jump taken only when C or Z is 0
// - lower-same jump taken only when C or Z is 1
// - less-equal jump taken when N xor V is 1 or Z is 1
// - less jump taken only when exactly one of N, V is set
// - minus jump taken only when N is 1
// - plus jump taken only when N is 0
// - always jump, both forms, loads pc plus offset unconditionally
// - bit test ANDs accumulator and operand; sets N, Z, clears V only
module stb_unit (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [7:0]              shift_result,
  output stb_pkg::stb_flags_s     flags_out,
  output logic                    jump_taken,
  output logic [15:0]             jump_target,
  output logic [15:0]             pc_out,
  output logic                    exec_done
);

  stb_pkg::stb_state_s st_reg;
  stb_pkg::stb_state_s st_next;
  logic [31:0]         wr_word;
  logic [31:0]         rd_word;
  logic                rd_ok;
  logic [7:0]          wr_addr;
  logic [7:0]          rd_addr;
  logic [15:0]         seq_pc;
  logic [15:0]         offs_ext;
  logic [7:0]          tst_val;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge so partial writes keep the untouched lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // condition test; unknown codes never jump
  function automatic logic cond_met(input logic [3:0] cc, input stb_pkg::stb_flags_s f);
    logic r;
    r = 1'b0;
    case (cc)
      stb_pkg::CC_JUMP_ALWAYS:           r = 1'b1;
      stb_pkg::CC_JUMP_IF_HIGHER:        r = ((f.c | f.z) == 1'b0);
      stb_pkg::CC_JUMP_IF_LOWER_SAME:    r = ((f.c | f.z) == 1'b1);
      stb_pkg::CC_JUMP_IF_CARRY_CLEAR:   r = (f.c == 1'b0);
      stb_pkg::CC_JUMP_IF_CARRY_SET:     r = (f.c == 1'b1);
      stb_pkg::CC_JUMP_IF_NOT_EQUAL:     r = (f.z == 1'b0);
      stb_pkg::CC_JUMP_IF_EQUAL:         r = (f.z == 1'b1);
      stb_pkg::CC_JUMP_IF_PLUS:          r = (f.n == 1'b0);
      stb_pkg::CC_JUMP_IF_MINUS:         r = (f.n == 1'b1);
      stb_pkg::CC_JUMP_IF_GREATER_EQUAL: r = ((f.n ^ f.v) == 1'b0);
      stb_pkg::CC_JUMP_IF_LESS:          r = ((f.n ^ f.v) == 1'b1);
      stb_pkg::CC_JUMP_IF_GREATER:       r = ((f.z | (f.n ^ f.v)) == 1'b0);
      stb_pkg::CC_JUMP_IF_LESS_EQUAL:    r = ((f.n ^ f.v) | f.z);
      default:                           r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic cond_known(input logic [3:0] cc);
    return cc <= stb_pkg::CC_JUMP_IF_LESS_EQUAL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes straight from state

  assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // user-side view
  assign shift_result = st_reg.result;
  assign flags_out    = st_reg.flags;
  assign jump_taken   = st_reg.taken;
  assign jump_target  = st_reg.target;
  assign pc_out       = st_reg.pc;
  assign exec_done    = st_reg.done;

  // datapath terms for the execute cycle
  assign wr_addr  = {st_reg.aw_addr[7:stb_pkg::WORD_LSB], 2'h0};
  assign rd_addr  = {s_axi_araddr[7:stb_pkg::WORD_LSB], 2'h0};
  assign seq_pc   = st_reg.pc + (st_reg.op_long ? stb_pkg::LONG_LEN : stb_pkg::SHORT_LEN);
  assign offs_ext = st_reg.op_long ? st_reg.offset
                                   : {{8{st_reg.offset[7]}}, st_reg.offset[7:0]};
  assign tst_val  = st_reg.accum & st_reg.operand;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    wr_word      = '0;
    rd_word      = '0;
    rd_ok        = 1'b1;

    // address and data are taken independently, in any order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end

    // writes wait while an operation executes, so the two never collide
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid && st_reg.fsm == stb_pkg::ST_IDLE)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = stb_pkg::RESP_OKAY;
      case (wr_addr)
        stb_pkg::OFS_OP:
        begin
          wr_word = lane_merge({23'h0, st_reg.op_long, 3'h0, st_reg.op}, st_reg.w_data, st_reg.w_strb);
          st_next.op      = wr_word[4:0];
          st_next.op_long = wr_word[stb_pkg::OP_LONG_BIT];
          st_next.fsm     = stb_pkg::ST_EXEC;
        end
        stb_pkg::OFS_OPND:
        begin
          wr_word = lane_merge({16'h0, st_reg.accum, st_reg.operand}, st_reg.w_data, st_reg.w_strb);
          st_next.operand = wr_word[7:0];
          st_next.accum   = wr_word[stb_pkg::OPND_ACC_LSB +: 8];
        end
        stb_pkg::OFS_OFFSET:
        begin
          wr_word = lane_merge({16'h0, st_reg.offset}, st_reg.w_data, st_reg.w_strb);
          st_next.offset = wr_word[15:0];
        end
        stb_pkg::OFS_PC:
        begin
          wr_word = lane_merge({16'h0, st_reg.pc}, st_reg.w_data, st_reg.w_strb);
          st_next.pc = wr_word[15:0];
        end
        stb_pkg::OFS_FLAGS:
        begin
          wr_word = lane_merge({27'h0, st_reg.flags}, st_reg.w_data, st_reg.w_strb);
          st_next.flags = wr_word[4:0];
        end
        stb_pkg::OFS_RESULT:
        begin
          wr_word = '0; // read-only, write dropped with okay
        end
        default:
        begin
          st_next.bresp = stb_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read path: one outstanding read, data latched at the address edge
    case (rd_addr)
      stb_pkg::OFS_OP:     rd_word = {23'h0, st_reg.op_long, 3'h0, st_reg.op};
      stb_pkg::OFS_OPND:   rd_word = {16'h0, st_reg.accum, st_reg.operand};
      stb_pkg::OFS_OFFSET: rd_word = {16'h0, st_reg.offset};
      stb_pkg::OFS_PC:     rd_word = {16'h0, st_reg.pc};
      stb_pkg::OFS_FLAGS:  rd_word = {27'h0, st_reg.flags};
      stb_pkg::OFS_RESULT: rd_word = {st_reg.target, 6'h0, st_reg.bad_op, st_reg.taken, st_reg.result};
      default:             rd_ok   = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word;
      st_next.rresp  = rd_ok ? stb_pkg::RESP_OKAY : stb_pkg::RESP_SLVERR;
    end
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end

    // execute: a single cycle after the operation register is written
    case (st_reg.fsm)
      stb_pkg::ST_IDLE:
      begin
        // no assignment here: an op write above may have raised execute, and idle must not undo it
      end
      stb_pkg::ST_EXEC:
      begin
        st_next.fsm    = stb_pkg::ST_IDLE;
        st_next.done   = 1'b1;
        st_next.bad_op = 1'b0;
        if (st_reg.op[stb_pkg::OP_JUMP_BIT])
        begin
          // flags are never touched on the jump path
          if (cond_known(st_reg.op[3:0]))
          begin
            st_next.target = seq_pc + offs_ext;
            st_next.taken  = cond_met(st_reg.op[3:0], st_reg.flags);
            st_next.pc     = st_next.taken ? seq_pc + offs_ext : seq_pc;
          end
          else
          begin
            st_next.bad_op = 1'b1;
          end
        end
        else
        begin
          case (st_reg.op)
            stb_pkg::OP_SHIFT_LEFT_ARITH:
            begin
              st_next.result  = {st_reg.operand[6:0], 1'b0};
              st_next.flags.c = st_reg.operand[7];
              st_next.flags.v = st_reg.operand[7] ^ st_reg.operand[6];
              st_next.flags.n = st_reg.operand[6];
              st_next.flags.z = (st_reg.operand[6:0] == 7'h00);
            end
            stb_pkg::OP_SHIFT_RIGHT_ARITH:
            begin
              // half-carry undefined, left as it was
              st_next.result  = {st_reg.operand[7], st_reg.operand[7:1]};
              st_next.flags.c = st_reg.operand[0];
              st_next.flags.n = st_reg.operand[7];
              st_next.flags.z = (st_reg.operand[7:1] == 7'h00);
            end
            stb_pkg::OP_BIT_TEST:
            begin
              // the AND value is discarded; result register keeps its value
              st_next.flags.n = tst_val[7];
              st_next.flags.z = (tst_val == 8'h00);
              st_next.flags.v = 1'b0;
            end
            default:
            begin
              st_next.bad_op = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        st_next.fsm = stb_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_reg       <= '0;
      st_reg.fsm   <= stb_pkg::ST_IDLE;
      st_reg.pc    <= stb_pkg::PC_RST;
      st_reg.flags <= stb_pkg::FLAGS_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic ex_shl;
  logic ex_shr;
  logic ex_tst;
  logic ex_jmp;
  assign ex_shl = st_reg.fsm == stb_pkg::ST_EXEC && st_reg.op == stb_pkg::OP_SHIFT_LEFT_ARITH;
  assign ex_shr = st_reg.fsm == stb_pkg::ST_EXEC && st_reg.op == stb_pkg::OP_SHIFT_RIGHT_ARITH;
  assign ex_tst = st_reg.fsm == stb_pkg::ST_EXEC && st_reg.op == stb_pkg::OP_BIT_TEST;
  assign ex_jmp = st_reg.fsm == stb_pkg::ST_EXEC && st_reg.op[stb_pkg::OP_JUMP_BIT] && cond_known(st_reg.op[3:0]);

  shl_result_a: assert property (ex_shl |=> shift_result == {$past(st_reg.operand[6:0]), 1'b0}
                                  && flags_out.c == $past(st_reg.operand[7]) && exec_done)
    else $error("left shift result or carry wrong");
  shl_flags_a: assert property (ex_shl |=> flags_out.v == ^$past(st_reg.operand[7:6])
                                 && flags_out.n == shift_result[7] && flags_out.z == (shift_result == 8'h00))
    else $error("left shift flags wrong");
  shr_result_a: assert property (ex_shr |=> shift_result[7] == shift_result[6]
                                  && shift_result[6:0] == $past(st_reg.operand[7:1]))
    else $error("right shift result wrong");
  shr_flags_a: assert property (ex_shr |=> flags_out.c == $past(st_reg.operand[0])
                                 && $stable(flags_out.v) && flags_out.n == shift_result[7])
    else $error("right shift flags wrong");
  bit_test_a: assert property (ex_tst |=> $stable(shift_result) && $stable(flags_out.c)
                                && !flags_out.v && flags_out.z == ($past(tst_val) == 8'h00))
    else $error("bit test flags or result wrong");
  jump_flags_a: assert property (ex_jmp |=> $stable(flags_out))
    else $error("jump changed flags");
  untaken_pc_a: assert property (ex_jmp ##1 !jump_taken |-> pc_out == $past(seq_pc))
    else $error("untaken jump pc wrong");
  short_target_a: assert property (ex_jmp && !st_reg.op_long |=>
                                    jump_target == $past(seq_pc) + {{8{$past(st_reg.offset[7])}},
                                    $past(st_reg.offset[7:0])})
    else $error("short jump target wrong");
  long_target_a: assert property (ex_jmp && st_reg.op_long |=>
                                   jump_target == $past(seq_pc) + $past(st_reg.offset))
    else $error("long jump target wrong");
  taken_pc_a: assert property (ex_jmp ##1 jump_taken |-> pc_out == jump_target)
    else $error("taken jump pc wrong");
  always_jump_a: assert property (ex_jmp && st_reg.op[3:0] == stb_pkg::CC_JUMP_ALWAYS |=> jump_taken)
    else $error("always jump not taken");
  greater_cond_a: assert property (ex_jmp && st_reg.op[3:0] == stb_pkg::CC_JUMP_IF_GREATER |=>
                                    jump_taken == !(flags_out.z | (flags_out.n ^ flags_out.v)))
    else $error("greater condition wrong");

  long_taken_c: cover property (ex_jmp && st_reg.op_long ##1 jump_taken);
  short_untaken_c: cover property (ex_jmp && !st_reg.op_long ##1 !jump_taken);
  shl_ovf_c: cover property (ex_shl ##1 flags_out.v);
  bit_test_c: cover property (ex_tst ##1 flags_out.z);

endmodule

//--- rtl/stb_pkg.sv
package stb_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] OFS_OP     = 8'h00;
  localparam logic [7:0] OFS_OPND   = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0c;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;

  // field positions
  localparam int unsigned OP_LONG_BIT  = 8;
  localparam int unsigned OPND_ACC_LSB = 8;
  localparam int unsigned RES_TAKEN    = 8;
  localparam int unsigned RES_BADOP    = 9;
  localparam int unsigned RES_TGT_LSB  = 16;
  localparam int unsigned WORD_LSB     = 2;

  // operation codes; bit 4 marks the relative jump family
  localparam logic [4:0] OP_SHIFT_LEFT_ARITH  = 5'h00;
  localparam logic [4:0] OP_SHIFT_RIGHT_ARITH = 5'h01;
  localparam logic [4:0] OP_BIT_TEST          = 5'h02;
  localparam int unsigned OP_JUMP_BIT         = 4;

  // jump conditions, low four bits of a jump operation
  localparam logic [3:0] CC_JUMP_ALWAYS           = 4'h0;
  localparam logic [3:0] CC_JUMP_IF_HIGHER        = 4'h1;
  localparam logic [3:0] CC_JUMP_IF_LOWER_SAME    = 4'h2;
  localparam logic [3:0] CC_JUMP_IF_CARRY_CLEAR   = 4'h3;
  localparam logic [3:0] CC_JUMP_IF_CARRY_SET     = 4'h4;
  localparam logic [3:0] CC_JUMP_IF_NOT_EQUAL     = 4'h5;
  localparam logic [3:0] CC_JUMP_IF_EQUAL         = 4'h6;
  localparam logic [3:0] CC_JUMP_IF_PLUS          = 4'h7;
  localparam logic [3:0] CC_JUMP_IF_MINUS         = 4'h8;
  localparam logic [3:0] CC_JUMP_IF_GREATER_EQUAL = 4'h9;
  localparam logic [3:0] CC_JUMP_IF_LESS          = 4'ha;
  localparam logic [3:0] CC_JUMP_IF_GREATER       = 4'hb;
  localparam logic [3:0] CC_JUMP_IF_LESS_EQUAL    = 4'hc;
  // aliases share the machine encoding, no code of their own
  localparam logic [3:0] CC_JUMP_IF_HIGHER_SAME   = CC_JUMP_IF_CARRY_CLEAR;
  localparam logic [3:0] CC_JUMP_IF_LOWER         = CC_JUMP_IF_CARRY_SET;

  // instruction lengths: opcode plus offset bytes
  localparam logic [15:0] SHORT_LEN = 16'h0002;
  localparam logic [15:0] LONG_LEN  = 16'h0003;

  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic {ST_IDLE, ST_EXEC} stb_fsm_e;

  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } stb_flags_s;

  localparam stb_flags_s FLAGS_RST = 5'h00;

  typedef struct packed {
    stb_fsm_e   fsm;
    logic       aw_have;
    logic [7:0] aw_addr;
    logic       w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] op;
    logic       op_long;
    logic [7:0] operand;
    logic [7:0] accum;
    logic [15:0] offset;
    logic [15:0] pc;
    stb_flags_s flags;
    logic [7:0] result;
    logic       taken;
    logic [15:0] target;
    logic       bad_op;
    logic       done;
  } stb_state_s;

endpackage

//--- test/stb_unit_tb.sv
`timescale 1ns/1ps

module stb_unit_tb;
  logic                clk_sys = 1'b0;
  logic                rst_b   = 1'b0;
  logic [7:0]          awa     = 8'h00;
  logic [7:0]          ara     = 8'h00;
  logic [31:0]         wd      = 32'h0;
  logic                awv     = 1'b0;
  logic                wv      = 1'b0;
  logic                bre     = 1'b0;
  logic                arv     = 1'b0;
  logic                rre     = 1'b0;
  logic                awr, wrd, bv, arr, rv, jt, ed;
  logic [1:0]          br, rr;
  logic [31:0]         rd, res, fl;
  logic [7:0]          sr;
  logic [15:0]         jtg, pco;
  stb_pkg::stb_flags_s fo;
  int                  mismatches = 0;
  int                  num_checks = 0;
  int                  n_done     = 0;

  always #50 clk_sys = ~clk_sys;

  stb_unit stb_unit_i (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .shift_result(sr), .flags_out(fo), .jump_taken(jt),
    .jump_target(jtg), .pc_out(pco), .exec_done(ed));

  // count execute pulses; one write of the op word must give exactly one
  always @(posedge clk_sys)
    if (ed === 1'b1)
      n_done <= n_done + 1;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge clk_sys);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(ah && wh))
    begin
      @(posedge clk_sys);
      if (!ah && awr === 1'b1)
      begin
        ah = 1'b1;
        awv <= 1'b0;
      end
      if (!wh && wrd === 1'b1)
      begin
        wh = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bv !== 1'b1);
    resp = br;
    bre <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ah;
    ah = 1'b0;
    @(posedge clk_sys);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (!ah && arr === 1'b1)
      begin
        ah = 1'b1;
        arv <= 1'b0;
      end
    end while (!(ah && rv === 1'b1));
    d = rd;
    resp = rr;
    rre <= 1'b0;
  endtask

  // load operands, start one execute, then fetch result and flag words
  task automatic exec(input logic [4:0] f, input logic [15:0] pc, input logic [15:0] off,
                      input logic [15:0] opnd, input logic [8:0] op);
    logic [1:0] r;
    int         nd;
    axw(stb_pkg::OFS_FLAGS, {27'h0, f}, r);
    axw(stb_pkg::OFS_PC, {16'h0, pc}, r);
    axw(stb_pkg::OFS_OFFSET, {16'h0, off}, r);
    axw(stb_pkg::OFS_OPND, {16'h0, opnd}, r);
    nd = n_done;
    axw(stb_pkg::OFS_OP, {23'h0, op}, r);
    axr(stb_pkg::OFS_RESULT, res, r);
    axr(stb_pkg::OFS_FLAGS, fl, r);
    chk("done pulses", n_done - nd, 32'h1);
    chk("flags port", {27'h0, fo}, fl);
  endtask

  task automatic t_reset_bus;
    logic [1:0]  r;
    logic [31:0] d;
    chk("pc after reset", {16'h0, pco}, 32'h0);
    chk("flags after reset", {27'h0, fo}, 32'h0);
    axw(8'h18, 32'h5555_aaaa, r);
    chk("unmapped write resp", {30'h0, r}, {30'h0, stb_pkg::RESP_SLVERR});
    axr(8'h18, d, r);
    chk("unmapped read resp", {30'h0, r}, {30'h0, stb_pkg::RESP_SLVERR});
    chk("unmapped read data", d, 32'h0);
    exec(5'h00, 16'h0, 16'h0, 16'h0, 9'h01d);
    chk("bad op flag", {31'h0, res[stb_pkg::RES_BADOP]}, 32'h1);
  endtask

  // shifts and bit test over sign, carry and zero corner operands
  task automatic t_shift_test;
    logic [7:0] ops [6] = '{8'hc1, 8'h40, 8'h00, 8'h81, 8'h01, 8'h7f};
    logic [7:0] o, e;
    foreach (ops[i])
    begin
      o = ops[i];
      exec(5'h10, 16'h0, 16'h0, {8'h00, o}, {4'h0, stb_pkg::OP_SHIFT_LEFT_ARITH});
      e = {o[6:0], 1'b0};
      chk("left result", {24'h0, sr}, {24'h0, e});
      chk("left flags", fl, {27'h0, 1'b1, e[7], e == 8'h00, o[7] ^ o[6], o[7]});
      exec({1'b1, 2'b00, o[1], ~o[0]}, 16'h0, 16'h0, {8'h00, o}, {4'h0, stb_pkg::OP_SHIFT_RIGHT_ARITH});
      e = {o[7], o[7:1]};
      chk("right result", {24'h0, res[7:0]}, {24'h0, e});
      chk("right flags", fl, {27'h0, 1'b1, e[7], e == 8'h00, o[1], o[0]});
      // accumulator has bit 7 set so the negative flag follows the operand's sign
      exec({o[2], 2'b00, 1'b1, o[3]}, 16'h0, 16'h0, {8'hc5, o}, {4'h0, stb_pkg::OP_BIT_TEST});
      chk("test flags", fl, {27'h0, o[2], o[7], (o & 8'hc5) == 8'h00, 1'b0, o[3]});
      chk("test keeps result", {24'h0, sr}, {24'h0, e});
    end
  endtask

  function automatic logic tk(input logic [3:0] cc, input logic [3:0] f);
    case (cc)
      stb_pkg::CC_JUMP_ALWAYS:           return 1'b1;
      stb_pkg::CC_JUMP_IF_HIGHER:        return !(f[0] | f[2]);
      stb_pkg::CC_JUMP_IF_LOWER_SAME:    return f[0] | f[2];
      stb_pkg::CC_JUMP_IF_CARRY_CLEAR:   return !f[0];
      stb_pkg::CC_JUMP_IF_CARRY_SET:     return f[0];
      stb_pkg::CC_JUMP_IF_NOT_EQUAL:     return !f[2];
      stb_pkg::CC_JUMP_IF_EQUAL:         return f[2];
      stb_pkg::CC_JUMP_IF_PLUS:          return !f[3];
      stb_pkg::CC_JUMP_IF_MINUS:         return f[3];
      stb_pkg::CC_JUMP_IF_GREATER_EQUAL: return !(f[3] ^ f[1]);
      stb_pkg::CC_JUMP_IF_LESS:          return f[3] ^ f[1];
      stb_pkg::CC_JUMP_IF_GREATER:       return !(f[2] | (f[3] ^ f[1]));
      default:                           return f[2] | (f[3] ^ f[1]);
    endcase
  endfunction

  // every condition against every n z v c pattern, both forms; pc near top to wrap
  task automatic t_jumps;
    logic [15:0] off, so, tg, sq;
    logic        t;
    for (int cc = 0; cc < 13; cc++)
      for (int f = 0; f < 16; f++)
        for (int lg = 0; lg < 2; lg++)
        begin
          off = (lg == 1) ? 16'h8123 : 16'h1280;
          so = (lg == 1) ? off : {{8{off[7]}}, off[7:0]};
          sq = 16'hfff0 + ((lg == 1) ? stb_pkg::LONG_LEN : stb_pkg::SHORT_LEN);
          tg = sq + so;
          t = tk(cc[3:0], f[3:0]);
          exec({1'b0, f[3:0]}, 16'hfff0, off, 16'h0, {lg[0], 4'b0001, cc[3:0]});
          chk("taken", {31'h0, jt}, {31'h0, t});
          chk("target", {16'h0, jtg}, {16'h0, tg});
          chk("next pc", {16'h0, pco}, {16'h0, t ? tg : sq});
          chk("jump flags", fl, {28'h0, f[3:0]});
        end
  endtask

  // bound of roughly three and a half times the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset_bus();
    t_shift_test();
    t_jumps();
    end_sim();
  end
endmodule
